// *** pmsi_params.svh ***
// offsets, field positions, reset values and timing figures of the state integrator
`ifndef PMSI_PARAMS_SVH
`define PMSI_PARAMS_SVH

`define PMSI_CLK_PERIOD_NS 50
`define PMSI_T_READ_NS     10000
`define PMSI_T_UPDATE_NS   5000
`define PMSI_T_SLEEP_NS    1000000
`define PMSI_T_WAKE_NS     100000
`define PMSI_CYC_UP(ns)    (((ns) + `PMSI_CLK_PERIOD_NS - 1) / `PMSI_CLK_PERIOD_NS)

`define PMSI_OFF_CTRL   8'h00
`define PMSI_OFF_STATUS 8'h04
`define PMSI_OFF_POWER  8'h08
`define PMSI_OFF_VSENSE 8'h0C
`define PMSI_OFF_VBUS   8'h10
`define PMSI_OFF_DAC    8'h14

`define PMSI_F_OVR    0
`define PMSI_F_INTEN  1
`define PMSI_F_SLEEP  2
`define PMSI_F_SEL    3
`define PMSI_F_RES14  5
`define PMSI_F_NSMP   6
`define PMSI_F_DI     10
`define PMSI_F_DV     13

`define PMSI_CTRL_RST 32'h0000_02E0
`define PMSI_CTRL_WMASK 32'h0000_7FFB

`endif

// *** pmsi_pkg.sv ***
// types shared by the state integrator files
package pmsi_pkg;
  typedef enum logic [1:0] {
    PMSI_ST_SLEEP = 2'b00,
    PMSI_ST_WAKE  = 2'b01,
    PMSI_ST_INTEG = 2'b10,
    PMSI_ST_READ  = 2'b11
  } pmsi_state_e;
  typedef enum logic [1:0] {
    PMSI_SEL_PWR_PIN = 2'b00,
    PMSI_SEL_VSNS_FR = 2'b01,
    PMSI_SEL_VBUS_FR = 2'b10,
    PMSI_SEL_PWR_FR  = 2'b11
  } pmsi_sel_e;
  typedef logic [15:0] pmsi_res_t;
endpackage : pmsi_pkg

// *** pmsi_sync.sv ***
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pmsi_sync (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;
  logic q_nxt;

  // s1 feeds only s2; the agree test looks at the later stages
  always_comb begin
    q_nxt = (s2_r == s3_r) ? s2_r : q_r;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_r  <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign dout = q_r;
endmodule : pmsi_sync
`default_nettype wire

// *** pmsi_avg.sv ***
// sample accumulator with a serial divider producing the period average
`timescale 1ns/1ps
`default_nettype none
module pmsi_avg (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        clear,
  input  wire logic        acc_en,
  input  wire logic        smp_vld,
  input  wire logic [27:0] smp,
  input  wire logic        finish,
  output logic             busy,
  output logic             done,
  output logic [27:0]      quot,
  output logic [15:0]      cnt
);
  logic [43:0] acc_r, acc_nxt, dvd_r, dvd_nxt;
  logic [15:0] cnt_r, cnt_nxt, dvs_r, dvs_nxt;
  logic [16:0] rem_r, rem_nxt, rem_sh;
  logic [5:0]  bit_r, bit_nxt;
  logic        busy_r, busy_nxt, done_r, done_nxt, take;

  // a finish hands the sum to the divider and restarts the sum in the same cycle,
  // so no sample is lost; a finish while dividing is ignored
  always_comb begin
    take     = finish && !busy_r && (cnt_r != 16'h0000);
    acc_nxt  = take ? 44'h0 : acc_r;
    cnt_nxt  = take ? 16'h0000 : cnt_r;
    dvd_nxt  = dvd_r;
    dvs_nxt  = dvs_r;
    rem_nxt  = rem_r;
    bit_nxt  = bit_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    rem_sh   = {rem_r[15:0], dvd_r[43]};
    // the count saturates; very long pin periods stop summing there
    if (acc_en && smp_vld && (cnt_nxt != 16'hFFFF)) begin
      acc_nxt = acc_nxt + {16'h0, smp};
      cnt_nxt = cnt_nxt + 16'h0001;
    end
    if (take) begin
      dvd_nxt  = acc_r;
      dvs_nxt  = cnt_r;
      rem_nxt  = 17'h0;
      bit_nxt  = 6'h2B;
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      // restoring division, one quotient bit per cycle
      if (rem_sh >= {1'b0, dvs_r}) begin
        rem_nxt = rem_sh - {1'b0, dvs_r};
        dvd_nxt = {dvd_r[42:0], 1'b1};
      end else begin
        rem_nxt = rem_sh;
        dvd_nxt = {dvd_r[42:0], 1'b0};
      end
      bit_nxt = bit_r - 6'h01;
      if (bit_r == 6'h00) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
    if (clear) begin
      acc_nxt  = 44'h0;
      cnt_nxt  = 16'h0000;
      busy_nxt = 1'b0;
      done_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_r  <= 44'h0;
      cnt_r  <= 16'h0000;
      dvd_r  <= 44'h0;
      dvs_r  <= 16'h0000;
      rem_r  <= 17'h0;
      bit_r  <= 6'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      acc_r  <= acc_nxt;
      cnt_r  <= cnt_nxt;
      dvd_r  <= dvd_nxt;
      dvs_r  <= dvs_nxt;
      rem_r  <= rem_nxt;
      bit_r  <= bit_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy = busy_r;
  assign done = done_r;
  assign quot = dvd_r[27:0];
  assign cnt  = cnt_r;
endmodule : pmsi_avg
`default_nettype wire

// *** pmsi_top.sv ***
// power-state control, integration and result registers behind an AXI4-Lite slave
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pmsi_params.svh"
// Function
// - pin high without override keeps the device integrating.
// - with override, writing integrate enable one starts integration.
// - without override, Read entered only after the pin stayed low for the read time.
// - with override, writing integrate enable zero enters Read.
// - Read entry stops summing, runs the idle timer, loads the DAC.
// - DAC value held until next period result or Sleep entry.
// - effective input low longer than the sleep time enters Sleep.
// - software sleep request enters Sleep.
// - Sleep entry clears results and accumulators, drops bias.
// - Sleep is kept until an integrate request arrives.
// - integration resumes after the wake delay following the request.
// - power mode sums products of bus and sense samples.
// - period sum divided by sample count into result registers.
// - averaged result scaled by gains, drives the 10-bit DAC.
// - power, sense or bus result to DAC and readable registers.
// - 11 or 14 bit resolution; free-run period set by sample count.
// - output select picks measurement type and integration mode.
// - free-run updates DAC each period; pin mode on Read or update.
module pmsi_top #(
  parameter logic [15:0] SLEEP_CYC = 16'(`PMSI_CYC_UP(`PMSI_T_SLEEP_NS))
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        integrate_read_pin,
  input  wire logic        adc_vld,
  input  wire logic [13:0] vbus_smp,
  input  wire logic [13:0] vsense_smp,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic [9:0]       dac_code,
  output logic [1:0]       power_state,
  output logic             bias_en
);
  localparam logic [15:0] READ_CYC = 16'(`PMSI_CYC_UP(`PMSI_T_READ_NS));
  localparam logic [15:0] UPD_CYC  = 16'(`PMSI_CYC_UP(`PMSI_T_UPDATE_NS));
  localparam logic [15:0] WAKE_CYC = 16'(`PMSI_CYC_UP(`PMSI_T_WAKE_NS));

  function automatic logic pmsi_mapped(input logic [7:0] a);
    pmsi_mapped = (a == `PMSI_OFF_CTRL) || (a == `PMSI_OFF_STATUS) ||
                  (a == `PMSI_OFF_POWER) || (a == `PMSI_OFF_VSENSE) ||
                  (a == `PMSI_OFF_VBUS) || (a == `PMSI_OFF_DAC);
  endfunction : pmsi_mapped

  // saturating left shift used for every digital gain
  function automatic pmsi_pkg::pmsi_res_t pmsi_scale(input logic [15:0] v,
                                                     input logic [3:0] sh);
    logic [31:0] w;
    w = {16'h0000, v} << sh;
    pmsi_scale = (|w[31:16]) ? 16'hFFFF : w[15:0];
  endfunction : pmsi_scale

  logic        pin_s;
  logic        aw_rdy_r, aw_rdy_nxt, w_rdy_r, w_rdy_nxt, b_vld_r, b_vld_nxt;
  logic        ar_rdy_r, ar_rdy_nxt, r_vld_r, r_vld_nxt;
  logic [1:0]  b_resp_r, b_resp_nxt, r_resp_r, r_resp_nxt;
  logic [7:0]  aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt, r_data_r, r_data_nxt, wmask, ctrl_r, ctrl_nxt;
  logic [3:0]  w_strb_r, w_strb_nxt;
  logic        wr_do, sleep_req;
  pmsi_pkg::pmsi_state_e state_r, state_nxt;
  pmsi_pkg::pmsi_sel_e   sel;
  logic [15:0] low_r, low_nxt, wake_r, wake_nxt, smp_goal;
  logic        eff, read_go, finish, free_run, bias_nxt, clr;
  logic        avg_busy, avg_done, rv_r, rv_nxt;
  logic [27:0] avg_q, smp_val;
  logic [13:0] vb_m, vs_m;
  logic [15:0] avg_cnt;
  pmsi_pkg::pmsi_res_t pwr_r, pwr_nxt, vsn_r, vsn_nxt, vbs_r, vbs_nxt, res_scaled;
  logic [9:0]  dac_r, dac_nxt;

  pmsi_sync u_pin (
    .mclk (mclk),
    .rst  (rst),
    .din  (integrate_read_pin),
    .dout (pin_s)
  );

  // one write and one read under way; channels re-open after the response is taken
  always_comb begin
    aw_rdy_nxt  = aw_rdy_r;
    w_rdy_nxt   = w_rdy_r;
    b_vld_nxt   = b_vld_r;
    b_resp_nxt  = b_resp_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    ar_rdy_nxt  = ar_rdy_r;
    r_vld_nxt   = r_vld_r;
    r_resp_nxt  = r_resp_r;
    r_data_nxt  = r_data_r;
    wr_do       = !aw_rdy_r && !w_rdy_r && !b_vld_r;
    if (s_axi_awvalid && aw_rdy_r) begin
      aw_rdy_nxt  = 1'b0;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && w_rdy_r) begin
      w_rdy_nxt  = 1'b0;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (wr_do) begin
      b_vld_nxt  = 1'b1;
      b_resp_nxt = pmsi_mapped(aw_addr_r) ? 2'h0 : 2'h2;
    end
    if (b_vld_r && s_axi_bready) begin
      b_vld_nxt  = 1'b0;
      aw_rdy_nxt = 1'b1;
      w_rdy_nxt  = 1'b1;
    end
    if (s_axi_arvalid && ar_rdy_r) begin
      ar_rdy_nxt = 1'b0;
      r_vld_nxt  = 1'b1;
      r_resp_nxt = pmsi_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      case (s_axi_araddr)
        `PMSI_OFF_CTRL:   r_data_nxt = ctrl_r;
        `PMSI_OFF_STATUS: r_data_nxt = {29'h0, rv_r, state_r};
        `PMSI_OFF_POWER:  r_data_nxt = {16'h0000, pwr_r};
        `PMSI_OFF_VSENSE: r_data_nxt = {16'h0000, vsn_r};
        `PMSI_OFF_VBUS:   r_data_nxt = {16'h0000, vbs_r};
        `PMSI_OFF_DAC:    r_data_nxt = {22'h0, dac_r};
        default:          r_data_nxt = 32'h0000_0000;
      endcase
    end
    if (r_vld_r && s_axi_rready) begin
      r_vld_nxt  = 1'b0;
      ar_rdy_nxt = 1'b1;
    end
  end

  // control word; the sleep bit is a write-one pulse and always reads zero
  always_comb begin
    wmask     = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    ctrl_nxt  = ctrl_r;
    sleep_req = wr_do && (aw_addr_r == `PMSI_OFF_CTRL) && w_strb_r[0] &&
                w_data_r[`PMSI_F_SLEEP];
    if (wr_do && (aw_addr_r == `PMSI_OFF_CTRL)) begin
      ctrl_nxt = (ctrl_r & ~(wmask & `PMSI_CTRL_WMASK)) |
                 (w_data_r & wmask & `PMSI_CTRL_WMASK);
      if (ctrl_nxt[`PMSI_F_NSMP +: 4] > 4'hB) begin
        ctrl_nxt[`PMSI_F_NSMP +: 4] = 4'hB;
      end
    end
  end

  // power state machine with the shared low-time counter as read and idle timer
  always_comb begin
    sel      = pmsi_pkg::pmsi_sel_e'(ctrl_r[`PMSI_F_SEL +: 2]);
    free_run = (sel != pmsi_pkg::PMSI_SEL_PWR_PIN);
    eff      = ctrl_r[`PMSI_F_OVR] ? ctrl_r[`PMSI_F_INTEN] : pin_s;
    low_nxt  = eff ? 16'h0000 : ((low_r == 16'hFFFF) ? low_r : low_r + 16'h0001);
    read_go  = !eff && (ctrl_r[`PMSI_F_OVR] || (low_r >= READ_CYC - 16'h0001));
    smp_goal = 16'h0001 << ctrl_r[`PMSI_F_NSMP +: 4];
    state_nxt = state_r;
    wake_nxt  = 16'h0000;
    finish    = 1'b0;
    case (state_r)
      pmsi_pkg::PMSI_ST_SLEEP: begin
        if (eff && !sleep_req) begin
          state_nxt = pmsi_pkg::PMSI_ST_WAKE;
        end
      end
      pmsi_pkg::PMSI_ST_WAKE: begin
        wake_nxt = wake_r + 16'h0001;
        if (sleep_req || !eff) begin
          state_nxt = pmsi_pkg::PMSI_ST_SLEEP;
        end else if (wake_r >= WAKE_CYC - 16'h0001) begin
          state_nxt = pmsi_pkg::PMSI_ST_INTEG;
        end
      end
      pmsi_pkg::PMSI_ST_INTEG: begin
        if (sleep_req) begin
          state_nxt = pmsi_pkg::PMSI_ST_SLEEP;
        end else if (read_go) begin
          state_nxt = pmsi_pkg::PMSI_ST_READ;
          finish    = 1'b1;
        end else if (free_run) begin
          finish = (avg_cnt >= smp_goal);
        end else begin
          finish = !eff && (low_r == UPD_CYC - 16'h0001);
        end
      end
      pmsi_pkg::PMSI_ST_READ: begin
        if (sleep_req || (low_r >= SLEEP_CYC)) begin
          state_nxt = pmsi_pkg::PMSI_ST_SLEEP;
        end else if (eff) begin
          state_nxt = pmsi_pkg::PMSI_ST_INTEG;
        end
      end
      default: state_nxt = pmsi_pkg::PMSI_ST_SLEEP;
    endcase
    clr      = (state_nxt == pmsi_pkg::PMSI_ST_SLEEP);
    bias_nxt = !clr;
  end

  // sample selection, resolution truncation and product for power mode
  always_comb begin
    vb_m = ctrl_r[`PMSI_F_RES14] ? vbus_smp : {vbus_smp[13:3], 3'h0};
    vs_m = ctrl_r[`PMSI_F_RES14] ? vsense_smp : {vsense_smp[13:3], 3'h0};
    case (sel)
      pmsi_pkg::PMSI_SEL_VSNS_FR: smp_val = {14'h0, vs_m};
      pmsi_pkg::PMSI_SEL_VBUS_FR: smp_val = {14'h0, vb_m};
      default:                    smp_val = vb_m * vs_m;
    endcase
  end

  pmsi_avg u_avg (
    .mclk    (mclk),
    .rst     (rst),
    .clear   (clr),
    .acc_en  (state_r == pmsi_pkg::PMSI_ST_INTEG),
    .smp_vld (adc_vld),
    .smp     (smp_val),
    .finish  (finish),
    .busy    (avg_busy),
    .done    (avg_done),
    .quot    (avg_q),
    .cnt     (avg_cnt)
  );

  // store the averaged result of the selected type and refresh the DAC from it
  always_comb begin
    pwr_nxt = pwr_r;
    vsn_nxt = vsn_r;
    vbs_nxt = vbs_r;
    dac_nxt = dac_r;
    rv_nxt  = rv_r;
    case (sel)
      pmsi_pkg::PMSI_SEL_VSNS_FR:
        res_scaled = pmsi_scale({avg_q[13:0], 2'h0}, {1'b0, ctrl_r[`PMSI_F_DI +: 3]});
      pmsi_pkg::PMSI_SEL_VBUS_FR:
        res_scaled = pmsi_scale({avg_q[13:0], 2'h0}, {2'h0, ctrl_r[`PMSI_F_DV +: 2]});
      default:
        res_scaled = pmsi_scale(avg_q[27:12], {1'b0, ctrl_r[`PMSI_F_DI +: 3]} +
                                {2'h0, ctrl_r[`PMSI_F_DV +: 2]});
    endcase
    if (avg_done) begin
      rv_nxt  = 1'b1;
      dac_nxt = res_scaled[15:6];
      case (sel)
        pmsi_pkg::PMSI_SEL_VSNS_FR: vsn_nxt = res_scaled;
        pmsi_pkg::PMSI_SEL_VBUS_FR: vbs_nxt = res_scaled;
        default:                    pwr_nxt = res_scaled;
      endcase
    end
    if (clr) begin
      pwr_nxt = 16'h0000;
      vsn_nxt = 16'h0000;
      vbs_nxt = 16'h0000;
      dac_nxt = 10'h000;
      rv_nxt  = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_rdy_r  <= 1'b1;
      w_rdy_r   <= 1'b1;
      b_vld_r   <= 1'b0;
      b_resp_r  <= 2'h0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      ar_rdy_r  <= 1'b1;
      r_vld_r   <= 1'b0;
      r_resp_r  <= 2'h0;
      r_data_r  <= 32'h0000_0000;
      ctrl_r    <= `PMSI_CTRL_RST;
      state_r   <= pmsi_pkg::PMSI_ST_SLEEP;
      low_r     <= 16'h0000;
      wake_r    <= 16'h0000;
      bias_en   <= 1'b0;
      pwr_r     <= 16'h0000;
      vsn_r     <= 16'h0000;
      vbs_r     <= 16'h0000;
      dac_r     <= 10'h000;
      rv_r      <= 1'b0;
    end else begin
      aw_rdy_r  <= aw_rdy_nxt;
      w_rdy_r   <= w_rdy_nxt;
      b_vld_r   <= b_vld_nxt;
      b_resp_r  <= b_resp_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      ar_rdy_r  <= ar_rdy_nxt;
      r_vld_r   <= r_vld_nxt;
      r_resp_r  <= r_resp_nxt;
      r_data_r  <= r_data_nxt;
      ctrl_r    <= ctrl_nxt;
      state_r   <= state_nxt;
      low_r     <= low_nxt;
      wake_r    <= wake_nxt;
      bias_en   <= bias_nxt;
      pwr_r     <= pwr_nxt;
      vsn_r     <= vsn_nxt;
      vbs_r     <= vbs_nxt;
      dac_r     <= dac_nxt;
      rv_r      <= rv_nxt;
    end
  end

  assign s_axi_awready = aw_rdy_r;
  assign s_axi_wready  = w_rdy_r;
  assign s_axi_bvalid  = b_vld_r;
  assign s_axi_bresp   = b_resp_r;
  assign s_axi_arready = ar_rdy_r;
  assign s_axi_rvalid  = r_vld_r;
  assign s_axi_rresp   = r_resp_r;
  assign s_axi_rdata   = r_data_r;
  assign dac_code      = dac_r;
  assign power_state   = state_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_read_to_integ: assert property ((state_r == pmsi_pkg::PMSI_ST_READ) && eff && !sleep_req
    && (low_r < SLEEP_CYC) |=> state_r == pmsi_pkg::PMSI_ST_INTEG)
    else $error("read did not return to integrate");
  a_ovr_read: assert property ((state_r == pmsi_pkg::PMSI_ST_INTEG) && ctrl_r[0] && !ctrl_r[1]
    && !sleep_req |=> state_r == pmsi_pkg::PMSI_ST_READ)
    else $error("override zero did not enter read");
  a_read_min_low: assert property ($rose(state_r == pmsi_pkg::PMSI_ST_READ) |->
    $past(ctrl_r[0]) || (low_r >= READ_CYC))
    else $error("read entered before minimum low time");
  a_sleep_clear: assert property ($rose(state_r == pmsi_pkg::PMSI_ST_SLEEP) |->
    pwr_r == 16'h0000 && vsn_r == 16'h0000 && vbs_r == 16'h0000 && dac_r == 10'h000
    && !bias_en)
    else $error("sleep entry left results set");
  a_sleep_stays: assert property ((state_r == pmsi_pkg::PMSI_ST_SLEEP) && !eff |=>
    state_r == pmsi_pkg::PMSI_ST_SLEEP)
    else $error("left sleep without request");
  a_wake_early: assert property ((state_r == pmsi_pkg::PMSI_ST_WAKE) &&
    (wake_r < WAKE_CYC - 16'h0001) |=> state_r != pmsi_pkg::PMSI_ST_INTEG)
    else $error("integration began before wake delay");
  a_idle_sleep: assert property ((state_r == pmsi_pkg::PMSI_ST_READ) && (low_r >= SLEEP_CYC)
    |=> state_r == pmsi_pkg::PMSI_ST_SLEEP)
    else $error("idle timeout did not enter sleep");
  a_sleep_req: assert property (sleep_req |=> state_r == pmsi_pkg::PMSI_ST_SLEEP)
    else $error("sleep request ignored");
  a_idle_clear: assert property (eff |=> low_r == 16'h0000)
    else $error("idle timer not cleared");
  a_dac_hold: assert property ((state_r == pmsi_pkg::PMSI_ST_READ) && !avg_done |=>
    (dac_r == $past(dac_r)) || (state_r == pmsi_pkg::PMSI_ST_SLEEP))
    else $error("dac changed while held");
  a_dac_load: assert property (avg_done && !clr |=> dac_r == $past(res_scaled[15:6]))
    else $error("dac not loaded from scaled result");

  c_read_entry: cover property ($rose(state_r == pmsi_pkg::PMSI_ST_READ));
  c_auto_sleep: cover property ((state_r == pmsi_pkg::PMSI_ST_READ) ##1
    (state_r == pmsi_pkg::PMSI_ST_SLEEP));
  c_wake_integ: cover property ((state_r == pmsi_pkg::PMSI_ST_WAKE) ##1
    (state_r == pmsi_pkg::PMSI_ST_INTEG));
  c_free_done: cover property (avg_done && free_run);
endmodule : pmsi_top
`default_nettype wire

// *** pmsi_host_model.sv ***
// host side model: drives the state pin and supplies converter samples
`timescale 1ns/1ps
`default_nettype none
module pmsi_host_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        pin_req,
  output logic             integrate_read_pin,
  output logic             adc_vld,
  output logic [13:0]      vbus_smp,
  output logic [13:0]      vsense_smp
);
  logic [1:0] div_r;
  // one sample every four cycles; the data lines carry the inverted sample value between strobes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end
  assign adc_vld    = (div_r == 2'h3);
  assign vbus_smp   = adc_vld ? 14'h1000 : ~14'h1000;
  assign vsense_smp = adc_vld ? 14'h1000 : ~14'h1000;
  // pin level follows the host request, held for whole phases
  assign integrate_read_pin = pin_req;
endmodule : pmsi_host_model
`default_nettype wire

// *** power_monitor_state_integrator_tb.sv ***
// self-checking bench for the power-state and integration control block
`timescale 1ns/1ps
`default_nettype none
module power_monitor_state_integrator_tb;
  logic mclk = 1'b0, rst = 1'b1, pin_req = 1'b0, pin, vld;
  logic [13:0] vb, vs;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rd;
  logic awready, wready, bvalid, arready, rvalid, bias_en;
  logic [1:0] bresp, rresp, power_state, br;
  logic [31:0] rdata;
  logic [9:0] dac_code;
  int n_fail = 0, n_compared = 0;
  always #25 mclk = ~mclk;
  pmsi_host_model host (.mclk(mclk), .rst(rst), .pin_req(pin_req), .integrate_read_pin(pin),
    .adc_vld(vld), .vbus_smp(vb), .vsense_smp(vs));
  pmsi_top #(.SLEEP_CYC(16'h012C)) dut (.mclk(mclk), .rst(rst), .integrate_read_pin(pin),
    .adc_vld(vld), .vbus_smp(vb), .vsense_smp(vs), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .dac_code(dac_code), .power_state(power_state), .bias_en(bias_en));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // address and data offered together, each released once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    br = bresp;
    bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read
  // bounded wait for a state, judged once the state appears or the limit is spent
  task automatic wait_st(input logic [1:0] s, input int lim);
    int n;
    n = 0;
    while (power_state !== s && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("power_state", {30'h0, power_state}, {30'h0, s});
  endtask : wait_st
  task automatic t_reset();
    logic [1:0] r;
    check("state after reset", {30'h0, power_state}, 32'h0000_0000);
    check("dac after reset", {22'h0, dac_code}, 32'h0000_0000);
    axi_read(8'h00, rd, r);
    check("ctrl reset", rd, 32'h0000_02E0);
  endtask : t_reset
  // pin wakes, integrates, reads after the low time, then sleeps and clears
  task automatic t_pin_cycle();
    logic [1:0] r;
    pin_req <= 1'b1;
    wait_st(2'b01, 10);
    wait_st(2'b10, 2100);
    check("bias on", {31'h0, bias_en}, 32'h0000_0001);
    repeat (200) @(posedge mclk);
    pin_req <= 1'b0;
    repeat (150) @(posedge mclk);
    #1;
    check("still integrating", {30'h0, power_state}, 32'h0000_0002);
    wait_st(2'b11, 100);
    repeat (60) @(posedge mclk);
    #1;
    check("dac power", {22'h0, dac_code}, 32'h0000_0040);
    axi_read(8'h08, rd, r);
    check("power result", rd, 32'h0000_1000);
    wait_st(2'b00, 200);
    check("bias off", {31'h0, bias_en}, 32'h0000_0000);
    check("dac cleared", {22'h0, dac_code}, 32'h0000_0000);
    axi_read(8'h08, rd, r);
    check("power cleared", rd, 32'h0000_0000);
  endtask : t_pin_cycle
  // override bit steers the states through software
  task automatic t_override();
    logic [1:0] r;
    axi_write(8'h00, 32'h0000_02E3);
    check("write resp", {30'h0, br}, 32'h0000_0000);
    wait_st(2'b01, 10);
    wait_st(2'b10, 2100);
    repeat (50) @(posedge mclk);
    axi_write(8'h00, 32'h0000_02E1);
    wait_st(2'b11, 5);
    axi_write(8'h00, 32'h0000_02E5);
    wait_st(2'b00, 3);
    repeat (400) @(posedge mclk);
    #1;
    check("sleep kept", {30'h0, power_state}, 32'h0000_0000);
    axi_read(8'h00, rd, r);
    check("ctrl readback", rd, 32'h0000_02E1);
  endtask : t_override
  task automatic t_unmapped();
    logic [1:0] r;
    axi_read(8'h40, rd, r);
    check("unmapped resp", {30'h0, r}, 32'h0000_0002);
    check("unmapped data", rd, 32'h0000_0000);
    axi_write(8'h40, 32'h0000_0001);
    check("unmapped write resp", {30'h0, br}, 32'h0000_0002);
  endtask : t_unmapped
  // free-run modes; the wait covers a mixed period left over from the previous select
  task automatic t_free(input logic [31:0] c, input logic [7:0] a, input logic [31:0] res,
                        input logic [9:0] dc);
    logic [1:0] r;
    axi_write(8'h00, c);
    wait_st(2'b10, 2100);
    repeat (200) @(posedge mclk);
    #1;
    check("free-run dac", {22'h0, dac_code}, {22'h0, dc});
    axi_read(a, rd, r);
    check("free-run result", rd, res);
    check("read resp", {30'h0, r}, 32'h0000_0000);
    axi_read(8'h14, rd, r);
    check("dac register", rd, {22'h0, dc});
    axi_read(8'h04, rd, r);
    check("status", rd, 32'h0000_0006);
  endtask : t_free
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    t_reset();
    t_pin_cycle();
    t_override();
    t_unmapped();
    t_free(32'h0000_048B, 8'h0C, 32'h0000_8000, 10'h200);
    t_free(32'h0000_2093, 8'h10, 32'h0000_8000, 10'h200);
    t_free(32'h0000_009B, 8'h08, 32'h0000_1000, 10'h040);
    tally_and_finish();
  end
  // the whole run needs about eight thousand cycles; the limit leaves ample margin
  initial begin
    #(30000 * 50);
    n_fail++;
    tally_and_finish();
  end
endmodule : power_monitor_state_integrator_tb
`default_nettype wire
